// ---- src/ptg_pkg.sv ----
// constants for the period timer with gate and one-shot modes
package ptg_pkg;
  // apb byte offsets, one word per register
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h04;
  localparam logic [7:0] PULSE_OFF  = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  // timer_control field positions
  localparam int RUN_BIT   = 0;
  localparam int CLKSEL_BIT = 1;
  localparam int PRE_LSB   = 4;
  localparam int PRE_W     = 3;
  localparam int POST_LSB  = 8;
  localparam int POST_W    = 4;
  localparam int MODE_LSB  = 16;
  localparam int MODE_W    = 5;
  // status field positions
  localparam int ST_PWM_BIT = 8;
  localparam int ST_RUN_BIT = 9;
  // mode field encodings
  localparam logic [4:0] MODE_GATE    = 5'h00;
  localparam logic [4:0] MODE_OS_SW   = 5'h08;
  localparam logic [4:0] MODE_OS_HW   = 5'h16;
  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  PERIOD_RST = 8'hff;
  localparam logic [7:0]  PULSE_RST  = 8'h00;
  // instruction clock is core clock divided by four
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
endpackage : ptg_pkg

// ---- src/ptg_timer.sv ----
// period-match timer with software gate and one-shot modes, apb slave
//
// Functional notes
// - software gate mode counts each selected clock while run is set, holds otherwise
// - count equal to period returns to zero on next counted clock, keeps counting in gate mode
// - one-shot match clears count and the timer's own run bit
// - mode value 01000 selects software-started one-shot
// - mode value 10110 selects level-triggered hardware-limit one-shot
// - pwm pulse starts in the cycle the run bit becomes set
// - pwm pulse ends when count matches the pulse width value
// - clearing run during pulse or before period match lengthens pwm timing
// - after a one-shot cycle pwm stays low until run is set again
// - a new one-shot cycle starts only on a fresh software set of run
// - external clock source: run and external reset delayed two timer clocks
// - instruction clock source: reset and run act after one instruction period
// - zero prescale and postscale fields give ratios of one to one
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module ptg_timer #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // apb slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // pins from outside the clock domain
  input  wire logic             ext_clk_i,
  input  wire logic             external_reset_source_i,
  // timer results toward the compare and pwm users
  output logic      [CNT_W-1:0] timer_count_o,
  output logic                  pwm_o,
  output logic                  period_match_o
);

  initial begin
    if (CNT_W != 8) $error("ptg_timer: only an 8-bit count is supported");
  end

  // apb decode, zero wait state: pready_o rises in the access cycle
  wire acc      = psel_i & penable_i & pready_o;
  wire wr       = acc & pwrite_i;
  wire hit_ctrl = (paddr_i == ptg_pkg::CTRL_OFF);
  wire hit_per  = (paddr_i == ptg_pkg::PERIOD_OFF);
  wire hit_pw   = (paddr_i == ptg_pkg::PULSE_OFF);
  wire hit_st   = (paddr_i == ptg_pkg::STATUS_OFF);
  wire hit_any  = hit_ctrl | hit_per | hit_pw | hit_st;
  wire wr_ctrl  = wr & hit_ctrl;
  wire set_req  = wr_ctrl & pwdata_i[ptg_pkg::RUN_BIT];

  // software state
  logic             run_q;
  logic             clk_sel_q;
  logic [2:0]       pre_sel_q;
  logic [3:0]       post_sel_q;
  logic [4:0]       mode_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] pulse_q;

  // a set only counts as a fresh start when run was clear
  wire run_rise = set_req & ~run_q;

  // synchronisers and timer state
  logic       xclk_m_q, xclk_s_q, xclk_p_q;
  logic       xr_m_q, xr_s_q, xr_t1_q, xr_t2_q;
  logic       run_s1_q, run_s2_q;
  logic [1:0] div_q;
  logic [6:0] pre_cnt_q;
  logic [3:0] post_cnt_q;

  // source tick: instruction clock or rising edge of the synced pin
  wire instr_tick = (div_q == ptg_pkg::INSTR_DIV_LAST);
  wire ext_tick   = xclk_s_q & ~xclk_p_q;
  wire src_tick   = clk_sel_q ? ext_tick : instr_tick;

  // external source uses two timer clocks of delay, instruction clock one
  wire run_eff  = clk_sel_q ? run_s2_q : run_s1_q;
  wire xr_eff   = clk_sel_q ? xr_t2_q : xr_t1_q;
  wire os_sw    = (mode_q == ptg_pkg::MODE_OS_SW);
  wire os_hw    = (mode_q == ptg_pkg::MODE_OS_HW);
  wire oneshot  = os_sw | os_hw;
  wire hold_rst = os_hw & xr_eff;

  // prescaler ratio is two to the power of the field, zero gives 1:1
  wire [6:0] pre_last = 7'((8'h01 << pre_sel_q) - 8'h01);
  wire pre_done = (pre_cnt_q == pre_last);
  wire tick     = src_tick & run_eff & pre_done & ~hold_rst;
  wire match    = (timer_count_o == period_q);
  wire pw_match = (timer_count_o == pulse_q);
  wire hw_clear = tick & match & oneshot;

  // read mux, unmapped reads give zero and an error
  wire [31:0] ctrl_rd = {11'h000, mode_q, 4'h0, post_sel_q, 1'b0, pre_sel_q,
                         2'b00, clk_sel_q, run_q};
  wire [31:0] st_rd   = {22'h000000, run_eff, pwm_o, timer_count_o};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_per  ? {24'h000000, period_q} :
                        hit_pw   ? {24'h000000, pulse_q} :
                        hit_st   ? st_rd : 32'h0000_0000;

  // bus answer registered in the setup cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i & ~pready_o;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h0000_0000;
      pslverr_o <= psel_i & ~penable_i & ~hit_any;
    end
  end

  // control and setup registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sel_q  <= ptg_pkg::CTRL_RST[ptg_pkg::CLKSEL_BIT];
      pre_sel_q  <= ptg_pkg::CTRL_RST[ptg_pkg::PRE_LSB +: ptg_pkg::PRE_W];
      post_sel_q <= ptg_pkg::CTRL_RST[ptg_pkg::POST_LSB +: ptg_pkg::POST_W];
      mode_q     <= ptg_pkg::CTRL_RST[ptg_pkg::MODE_LSB +: ptg_pkg::MODE_W];
      period_q   <= ptg_pkg::PERIOD_RST;
      pulse_q    <= ptg_pkg::PULSE_RST;
    end else begin
      if (wr_ctrl) begin
        clk_sel_q  <= pwdata_i[ptg_pkg::CLKSEL_BIT];
        pre_sel_q  <= pwdata_i[ptg_pkg::PRE_LSB +: ptg_pkg::PRE_W];
        post_sel_q <= pwdata_i[ptg_pkg::POST_LSB +: ptg_pkg::POST_W];
        mode_q     <= pwdata_i[ptg_pkg::MODE_LSB +: ptg_pkg::MODE_W];
      end
      if (wr & hit_per) period_q <= pwdata_i[CNT_W-1:0];
      if (wr & hit_pw) pulse_q <= pwdata_i[CNT_W-1:0];
    end
  end

  // run bit: a software set wins over the hardware clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= ptg_pkg::CTRL_RST[ptg_pkg::RUN_BIT];
    end else if (set_req) begin
      run_q <= 1'b1;
    end else if (hw_clear) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= 1'b0;
    end
  end

  // pin synchronisers; first stages are read only by the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xclk_m_q <= 1'b0;
      xclk_s_q <= 1'b0;
      xclk_p_q <= 1'b0;
      xr_m_q   <= 1'b0;
      xr_s_q   <= 1'b0;
      div_q    <= 2'h0;
    end else begin
      xclk_m_q <= ext_clk_i;
      xclk_s_q <= xclk_m_q;
      xclk_p_q <= xclk_s_q;
      xr_m_q   <= external_reset_source_i;
      xr_s_q   <= xr_m_q;
      div_q    <= div_q + 2'h1;
    end
  end

  // timer-clock delay stages; a one-shot end flushes the run pipeline so
  // the stale copy cannot restart the count
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      xr_t1_q  <= 1'b0;
      xr_t2_q  <= 1'b0;
    end else begin
      if (hw_clear) begin
        run_s1_q <= 1'b0;
        run_s2_q <= 1'b0;
      end else if (src_tick) begin
        run_s1_q <= run_q;
        run_s2_q <= run_s1_q;
      end
      if (src_tick) begin
        xr_t1_q <= xr_s_q;
        xr_t2_q <= xr_t1_q;
      end
    end
  end

  // prescaler counts selected source clocks while running
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_q <= 7'h00;
    end else if (hold_rst | hw_clear) begin
      pre_cnt_q <= 7'h00;
    end else if (src_tick & run_eff) begin
      pre_cnt_q <= pre_done ? 7'h00 : pre_cnt_q + 7'h01;
    end
  end

  // count register: hold, advance, or wrap to zero on period match
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_count_o <= '0;
    end else if (hold_rst) begin
      timer_count_o <= '0;
    end else if (tick) begin
      timer_count_o <= match ? '0 : timer_count_o + 8'h01;
    end
  end

  // postscaler: one match pulse out per post_sel_q+1 period matches
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_cnt_q     <= 4'h0;
      period_match_o <= 1'b0;
    end else begin
      period_match_o <= 1'b0;
      if (tick & match) begin
        if (post_cnt_q == post_sel_q) begin
          post_cnt_q     <= 4'h0;
          period_match_o <= 1'b1;
        end else begin
          post_cnt_q <= post_cnt_q + 4'h1;
        end
      end
    end
  end

  // pwm drive; the count holds while run is clear, so a high phase of
  // the pulse stretches by the time run stays cleared, while a fresh set of run ends a low phase by driving pwm high at once
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_o <= 1'b0;
    end else if (run_rise) begin
      pwm_o <= 1'b1;
    end else if (tick & pw_match) begin
      pwm_o <= 1'b0;
    end else if (tick & match & ~oneshot) begin
      pwm_o <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_gate_hold: assert property (!tick & !hold_rst |=> $stable(timer_count_o))
    else $error("count moved without a counted clock");
  chk_gate_adv: assert property (tick & !match & !hold_rst
                                 |=> timer_count_o == $past(timer_count_o) + 8'h01)
    else $error("count did not advance by one");
  chk_wrap_zero: assert property (tick & match |=> timer_count_o == '0)
    else $error("count did not return to zero on period match");
  chk_oneshot_stop: assert property (hw_clear & !set_req |=> !run_q ##1 !run_eff)
    else $error("one-shot did not clear run on match");
  chk_no_restart: assert property (oneshot & !run_q & !set_req |=> !run_q)
    else $error("run set without software");
  chk_hw_limit: assert property (os_hw & xr_eff |=> timer_count_o == '0)
    else $error("hardware limit did not hold count at zero");
  chk_pwm_start: assert property (run_rise |=> pwm_o)
    else $error("pwm did not start with run set");
  chk_pwm_end: assert property (tick & pw_match & !run_rise |=> !pwm_o)
    else $error("pwm did not end on pulse width match");
  chk_pwm_stretch: assert property (pwm_o & !run_eff & !run_rise |=> pwm_o)
    else $error("pwm ended while run was cleared");
  chk_os_idle: assert property (oneshot & !pwm_o & !run_q & !set_req |=> !pwm_o)
    else $error("pwm restarted without run set");
  chk_sync_delay: assert property (clk_sel_q & src_tick & run_q & !run_s1_q
                                   & !hw_clear |=> !run_eff)
    else $error("external-source run took effect too early");
  chk_prescale_one: assert property (pre_sel_q == 3'h0 & src_tick & run_eff
                                     & !hold_rst |-> tick)
    else $error("1:1 prescale skipped a clock");

endmodule : ptg_timer

// ---- verification/period_timer_gate_one_shot_tb.sv ----
// self-checking bench for the period timer with gate and one-shot modes
`timescale 1ns/1ps
module period_timer_gate_one_shot_tb;
  // stimulus
  logic        core_clk_i  = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        psel_i      = 1'b0;
  logic        penable_i   = 1'b0;
  logic        pwrite_i    = 1'b0;
  logic [7:0]  paddr_i     = 8'h00;
  logic [31:0] pwdata_i    = 32'h0000_0000;
  logic        ext_clk_i   = 1'b0;
  logic        ext_rst_src = 1'b0;
  // observed
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        pwm_o;
  logic        period_match_o;
  logic [7:0]  timer_count_o;
  logic [15:0] match_cnt;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  top;
  int          n_errors = 0;
  int          n_tests  = 0;

  // 250 MHz core clock
  always #2 core_clk_i = ~core_clk_i;

  ptg_timer #(.CNT_W(8)) ptg_timer_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i),
    .external_reset_source_i(ext_rst_src), .timer_count_o(timer_count_o), .pwm_o(pwm_o),
    .period_match_o(period_match_o));

  ptg_ccp_model ptg_ccp_model_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .period_match_i(period_match_o),
    .match_cnt_o(match_cnt));

  // verdict and end of run
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // one comparison of a 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; request held until pready is seen, result lands in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    k = 0;
    // pready, read data and error are taken at the rising edge that sees them
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no bus answer", $time);
      wrap_up();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // bounded wait for the pwm drive to reach a level
  task automatic wait_pwm(input logic v, input int lim);
    int k;
    k = 0;
    while (pwm_o !== v && k < lim) begin
      @(negedge core_clk_i);
      k++;
    end
    chk({31'h0, pwm_o}, {31'h0, v});
  endtask : wait_pwm

  // bounded poll of status until the timer drops its own run bit
  task automatic wait_run_clear();
    int k;
    k = 0;
    do begin
      apb(1'b0, ptg_pkg::STATUS_OFF, 32'h0);
      k++;
    end while (rd[ptg_pkg::ST_RUN_BIT] !== 1'b0 && k < 60);
  endtask : wait_run_clear

  // reset values and an unmapped access
  task automatic t_regs();
    apb(1'b0, ptg_pkg::CTRL_OFF, 32'h0);
    chk(rd, ptg_pkg::CTRL_RST);
    apb(1'b0, ptg_pkg::PERIOD_OFF, 32'h0);
    chk(rd, {24'h0, ptg_pkg::PERIOD_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h0000_0001);
    $display("test regs done");
  endtask : t_regs

  // gate mode: wrap at period, hold while run is low
  task automatic t_gate();
    top = 8'h00;
    apb(1'b1, ptg_pkg::PERIOD_OFF, 32'h0000_0003);
    apb(1'b1, ptg_pkg::CTRL_OFF, 32'h0000_0001);
    for (int k = 0; k < 300 && match_cnt < 16'h0002; k++) begin
      @(negedge core_clk_i);
      if (timer_count_o > top) top = timer_count_o;
    end
    chk({24'h0, top}, 32'h0000_0003);
    chk({31'h0, match_cnt >= 16'h0002}, 32'h0000_0001);
    apb(1'b1, ptg_pkg::CTRL_OFF, 32'h0000_0000);
    repeat (12) @(negedge core_clk_i);
    top = timer_count_o;
    repeat (40) @(negedge core_clk_i);
    chk({24'h0, timer_count_o}, {24'h0, top});
    $display("test gate done");
  endtask : t_gate

  // software one-shot: pulse, self-clear, no restart, fresh start
  task automatic t_oneshot();
    // the gate test leaves the count held mid-period; the limit level zeroes it
    ext_rst_src <= 1'b1;
    apb(1'b1, ptg_pkg::CTRL_OFF, 32'(ptg_pkg::MODE_OS_HW) << ptg_pkg::MODE_LSB);
    repeat (24) @(negedge core_clk_i);
    chk({24'h0, timer_count_o}, 32'h0000_0000);
    @(posedge core_clk_i);
    ext_rst_src <= 1'b0;
    repeat (24) @(negedge core_clk_i);
    apb(1'b1, ptg_pkg::PULSE_OFF, 32'h0000_0002);
    apb(1'b1, ptg_pkg::PERIOD_OFF, 32'h0000_0005);
    apb(1'b1, ptg_pkg::CTRL_OFF, (32'(ptg_pkg::MODE_OS_SW) << ptg_pkg::MODE_LSB) | 32'h1);
    wait_pwm(1'b1, 2);
    wait_pwm(1'b0, 100);
    apb(1'b0, ptg_pkg::STATUS_OFF, 32'h0);
    chk({31'h0, rd[ptg_pkg::ST_RUN_BIT]}, 32'h0000_0001);
    wait_run_clear();
    chk({22'h0, rd[9:0]}, 32'h0000_0000);
    repeat (40) @(negedge core_clk_i);
    chk({23'h0, pwm_o, timer_count_o}, 32'h0000_0000);
    apb(1'b1, ptg_pkg::CTRL_OFF, (32'(ptg_pkg::MODE_OS_SW) << ptg_pkg::MODE_LSB) | 32'h1);
    wait_pwm(1'b1, 2);
    wait_run_clear();
    $display("test one-shot done");
  endtask : t_oneshot

  // level-limited one-shot: a high limit level pins the count at zero
  task automatic t_hwlimit();
    ext_rst_src <= 1'b1;
    apb(1'b1, ptg_pkg::CTRL_OFF, (32'(ptg_pkg::MODE_OS_HW) << ptg_pkg::MODE_LSB) | 32'h1);
    repeat (40) @(negedge core_clk_i);
    apb(1'b0, ptg_pkg::STATUS_OFF, 32'h0);
    chk({23'h0, rd[ptg_pkg::ST_RUN_BIT], rd[7:0]}, 32'h0000_0100);
    @(posedge core_clk_i);
    ext_rst_src <= 1'b0;
    wait_run_clear();
    chk({31'h0, rd[ptg_pkg::ST_RUN_BIT]}, 32'h0000_0000);
    $display("test hw limit done");
  endtask : t_hwlimit

  // external pin clock, gate mode: first two pin edges only carry run through
  task automatic t_extclk();
    apb(1'b1, ptg_pkg::PERIOD_OFF, 32'h0000_0003);
    apb(1'b1, ptg_pkg::CTRL_OFF, 32'h0000_0003);
    repeat (20) begin
      @(posedge core_clk_i);
      ext_clk_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      ext_clk_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
    repeat (8) @(negedge core_clk_i);
    // 18 counted edges from zero with a wrap every four counts
    chk({24'h0, timer_count_o}, 32'h0000_0002);
    $display("test ext clock done");
  endtask : t_extclk

  // main sequence
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_gate();
    t_oneshot();
    t_hwlimit();
    t_extclk();
    wrap_up();
  end
endmodule : period_timer_gate_one_shot_tb

// ---- verification/ptg_ccp_model.sv ----
// behavioural compare-side user that tallies the timer's period matches
`timescale 1ns/1ps
module ptg_ccp_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // timer result
  input  wire logic        period_match_i,
  output logic      [15:0] match_cnt_o
);
  // a tally, not a pulse copy, so the bench never races a one-cycle strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_cnt_o <= 16'h0000;
    end else if (period_match_i) begin
      match_cnt_o <= match_cnt_o + 16'h0001;
    end
  end
endmodule : ptg_ccp_model
